//--- hdl/adcc_top.sv
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Analogue section powered only while enable high
// - Four ticks sampling, twelve converting, sixteen total
// - Conversion runs alone, no processor stall
// - Busy high throughout; result valid after
// - Start needs full low-high-low pulse
// - Internal input disconnects external channel
// - Analogue pin disables other pin functions
// - Analogue pin drops programmed pull-up
// - Analogue pin overrides port direction
// - Reference supply, pin or bandgap; gains 1-4
// - Interrupt needs global and converter enables
// - Result is 12-bit unsigned, full scale fff
// - Divider field derives converter clock
// - Format bit arranges result bytes
// - Divider codes give divide 1 to 128
// - Format 0: 11-4/3-0; format 1: 11-8/7-0
// - Completion sets interrupt request flag
module adcc_top #(
  parameter int PINS = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [adcc_pkg::ADCC_ADR_W-1:0] wb_adr_i,
  input wire logic [adcc_pkg::ADCC_SEL_W-1:0] wb_sel_i,
  input wire logic [adcc_pkg::ADCC_DAT_W-1:0] wb_dat_i,
  output logic [adcc_pkg::ADCC_DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Analogue front end
  input wire logic comp_i,
  output logic analog_power_o,
  output logic sample_o,
  output logic [adcc_pkg::ADCC_RES_W-1:0] sar_dac_o,
  output logic [PINS-1:0] ext_channel_o,
  output logic internal_en_o,
  output logic [adcc_pkg::ADCC_INSEL_W-1:0] internal_sel_o,
  output logic [1:0] ref_source_o,
  output logic [1:0] ref_gain_o,
  output logic gain_amp_en_o,
  output logic bandgap_en_o,
  // Pin function override
  input wire logic [PINS-1:0] port_dir_out_i,
  input wire logic [PINS-1:0] pullup_cfg_i,
  output logic [PINS-1:0] pin_analog_o,
  output logic [PINS-1:0] pin_digital_en_o,
  output logic [PINS-1:0] pin_out_en_n_o,
  output logic [PINS-1:0] pullup_en_o,
  // Interrupt
  output logic irq_o
);
  import adcc_pkg::*;

  logic [7:0] ctrl0_r, ctrl0_nxt;
  logic [7:0] ctrl1_r, ctrl1_nxt;
  logic [7:0] ctrl2_r, ctrl2_nxt;
  logic [2:0] irqc_r, irqc_nxt;
  logic [PINS-1:0] pinfn_r, pinfn_nxt;
  logic [ADCC_RES_W-1:0] result_r, result_nxt;
  logic [ADCC_RES_W-1:0] sar_r, sar_nxt;
  logic [ADCC_RES_W-1:0] trial_r, trial_nxt;
  logic [3:0] tick_cnt_r, tick_cnt_nxt;
  adcc_state_t state_r, state_nxt;
  logic ack_r, ack_nxt;
  logic [ADCC_DAT_W-1:0] rdat_r, rdat_nxt;
  logic comp_meta_r, comp_sync_r;
  logic conv_tick;
  logic wr_stb;
  logic start_wr, start_set, start_clr;
  logic done;
  logic busy;
  logic pwr;
  logic [7:0] res_hi, res_lo;
  logic ext_input;

  // Comparator crosses from the analogue side, so two flops first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      comp_meta_r <= 1'b0;
      comp_sync_r <= 1'b0;
    end else begin
      comp_meta_r <= comp_i;
      comp_sync_r <= comp_meta_r;
    end
  end

  assign pwr = ctrl0_r[ADCC_C0_PWR];

  // Converter clock enable, stopped while unpowered to save power
  adcc_clkdiv #(
    .SEL_W(ADCC_DIV_W),
    .CNT_W(7)
  ) u_clkdiv (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(pwr),
    .div_sel_i(ctrl1_r[ADCC_C1_DIV_LSB +: ADCC_DIV_W]),
    .tick_o(conv_tick)
  );

  // Bus write decode; only byte lane 0 carries register bits
  assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && wb_sel_i[0];
  assign start_wr = wr_stb && (wb_adr_i == ADCC_OFS_CTRL0);
  assign start_set = start_wr && wb_dat_i[ADCC_C0_START] && !ctrl0_r[ADCC_C0_START];
  assign start_clr = start_wr && !wb_dat_i[ADCC_C0_START] && ctrl0_r[ADCC_C0_START];

  // Conversion sequencer
  always_comb begin
    state_nxt = state_r;
    tick_cnt_nxt = tick_cnt_r;
    sar_nxt = sar_r;
    trial_nxt = trial_r;
    result_nxt = result_r;
    done = 1'b0;
    if (!pwr) begin
      state_nxt = ADCC_IDLE;
    end else if (start_set) begin
      state_nxt = ADCC_ARMED;
      tick_cnt_nxt = '0;
    end else begin
      unique case (state_r)
        ADCC_IDLE: begin
          tick_cnt_nxt = '0;
        end
        ADCC_ARMED: begin
          if (start_clr) begin
            state_nxt = ADCC_SAMPLE;
            tick_cnt_nxt = '0;
          end
        end
        ADCC_SAMPLE: begin
          if (conv_tick) begin
            tick_cnt_nxt = tick_cnt_r + 4'h1;
            if (tick_cnt_r == ADCC_SAMPLE_TICKS - 4'h1) begin
              state_nxt = ADCC_CONVERT;
              tick_cnt_nxt = '0;
              sar_nxt = '0;
              trial_nxt = ADCC_SAR_FIRST;
            end
          end
        end
        ADCC_CONVERT: begin
          if (conv_tick) begin
            // Keep the trial bit when input is at or above the trial level
            sar_nxt = comp_sync_r ? trial_r : sar_r;
            trial_nxt = (comp_sync_r ? trial_r : sar_r) | (trial_r ^ sar_r) >> 1;
            tick_cnt_nxt = tick_cnt_r + 4'h1;
            if (tick_cnt_r == ADCC_CONVERT_TICKS - 4'h1) begin
              state_nxt = ADCC_IDLE;
              result_nxt = (comp_sync_r ? trial_r : sar_r) & ADCC_FULL_SCALE;
              done = 1'b1;
            end
          end
        end
      endcase
    end
  end

  // Sequencer registers; result is kept while unpowered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ADCC_IDLE;
      tick_cnt_r <= '0;
      sar_r <= '0;
      trial_r <= '0;
      result_r <= '0;
    end else begin
      state_r <= state_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      sar_r <= sar_nxt;
      trial_r <= trial_nxt;
      result_r <= result_nxt;
    end
  end

  // Busy covers sampling and converting only
  assign busy = (state_r == ADCC_SAMPLE) || (state_r == ADCC_CONVERT);

  // Result byte arrangement
  always_comb begin
    if (ctrl0_r[ADCC_C0_FMT]) begin
      res_hi = {4'h0, result_r[11:8]};
      res_lo = result_r[7:0];
    end else begin
      res_hi = result_r[11:4];
      res_lo = {result_r[3:0], 4'h0};
    end
  end

  // Register writes; hardware flag set beats a software clear
  always_comb begin
    ctrl0_nxt = ctrl0_r;
    ctrl1_nxt = ctrl1_r;
    ctrl2_nxt = ctrl2_r;
    irqc_nxt = irqc_r;
    pinfn_nxt = pinfn_r;
    if (wr_stb) begin
      unique case (wb_adr_i)
        ADCC_OFS_CTRL0: ctrl0_nxt = wb_dat_i[7:0] & 8'hb7;
        ADCC_OFS_CTRL1: ctrl1_nxt = wb_dat_i[7:0] & 8'he7;
        ADCC_OFS_CTRL2: ctrl2_nxt = wb_dat_i[7:0] & 8'hcf;
        ADCC_OFS_IRQ: irqc_nxt = wb_dat_i[2:0];
        ADCC_OFS_PINFN: pinfn_nxt = wb_dat_i[PINS-1:0];
        default: ;
      endcase
    end
    if (done) begin
      irqc_nxt[ADCC_IRQ_FLAG] = 1'b1;
    end
  end

  // Register file
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl0_r <= ADCC_BYTE_RST;
      ctrl1_r <= ADCC_BYTE_RST;
      ctrl2_r <= ADCC_BYTE_RST;
      irqc_r <= '0;
      pinfn_r <= '0;
    end else begin
      ctrl0_r <= ctrl0_nxt;
      ctrl1_r <= ctrl1_nxt;
      ctrl2_r <= ctrl2_nxt;
      irqc_r <= irqc_nxt;
      pinfn_r <= pinfn_nxt;
    end
  end

  // Bus answer: one wait state, unmapped reads give zero
  always_comb begin
    ack_nxt = wb_cyc_i && wb_stb_i && !ack_r;
    rdat_nxt = '0;
    if (ack_nxt && !wb_we_i) begin
      unique case (wb_adr_i)
        ADCC_OFS_CTRL0: rdat_nxt[7:0] = {ctrl0_r[7], busy, ctrl0_r[5:0]};
        ADCC_OFS_CTRL1: rdat_nxt[7:0] = ctrl1_r;
        ADCC_OFS_CTRL2: rdat_nxt[7:0] = ctrl2_r;
        ADCC_OFS_RESH: rdat_nxt[7:0] = res_hi;
        ADCC_OFS_RESL: rdat_nxt[7:0] = res_lo;
        ADCC_OFS_IRQ: rdat_nxt[2:0] = irqc_r;
        ADCC_OFS_PINFN: rdat_nxt[PINS-1:0] = pinfn_r;
        default: ;
      endcase
    end
  end

  // Bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      rdat_r <= '0;
    end else begin
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // Input routing; internal sources cut the external mux off
  assign ext_input = (ctrl1_r[ADCC_C1_INSEL_LSB +: ADCC_INSEL_W] == ADCC_INSEL_EXT_A) ||
                     (ctrl1_r[ADCC_C1_INSEL_LSB +: ADCC_INSEL_W] == ADCC_INSEL_EXT_B);

  always_comb begin
    ext_channel_o = '0;
    if (pwr && ext_input) begin
      ext_channel_o[ctrl0_r[ADCC_C0_CH_LSB +: ADCC_CH_W]] = 1'b1;
    end
  end

  assign internal_en_o = pwr && !ext_input;
  assign internal_sel_o = ctrl1_r[ADCC_C1_INSEL_LSB +: ADCC_INSEL_W];

  // Reference and gain decode; unlisted codes fall back to supply
  always_comb begin
    ref_source_o = ADCC_SRC_SUPPLY;
    ref_gain_o = 2'h0;
    if (ctrl2_r[ADCC_REF_W-1:0] >= ADCC_REF_EXT_X1 && ctrl2_r[ADCC_REF_W-1:0] <= ADCC_REF_EXT_X4) begin
      ref_source_o = ADCC_SRC_EXTPIN;
      ref_gain_o = 2'(ctrl2_r[ADCC_REF_W-1:0] - ADCC_REF_EXT_X1);
    end else if (ctrl2_r[ADCC_REF_W-1:0] == ADCC_REF_BG_X1 ||
                 (ctrl2_r[ADCC_REF_W-1:0] >= ADCC_REF_BG_X2 && ctrl2_r[ADCC_REF_W-1:0] <= ADCC_REF_BG_X4)) begin
      ref_source_o = ADCC_SRC_BANDGAP;
      // Reserved slot after x1, so x2 upward counts from its own code
      ref_gain_o = (ctrl2_r[ADCC_REF_W-1:0] == ADCC_REF_BG_X1) ? 2'h0 :
                   2'(ctrl2_r[ADCC_REF_W-1:0] - ADCC_REF_BG_X2 + 4'h1);
    end
  end

  assign gain_amp_en_o = ctrl2_r[ADCC_C2_GAINEN];
  assign bandgap_en_o = ctrl2_r[ADCC_C2_BGEN];

  // Analogue drive, quiet from the cycle after power is removed
  assign analog_power_o = pwr;
  assign sample_o = (state_r == ADCC_SAMPLE);
  assign sar_dac_o = (state_r == ADCC_CONVERT) ? trial_r : '0;

  // Pin override: analogue use beats every digital setting
  assign pin_analog_o = pinfn_r;
  assign pin_digital_en_o = ~pinfn_r;
  assign pin_out_en_n_o = ~(port_dir_out_i & ~pinfn_r);
  assign pullup_en_o = pullup_cfg_i & ~pinfn_r;

  // Interrupt needs both enables as well as the flag
  assign irq_o = irqc_r[ADCC_IRQ_FLAG] && irqc_r[ADCC_IRQ_IE] && irqc_r[ADCC_IRQ_GIE];
endmodule
`default_nettype wire

//--- include/adcc_pkg.sv
package adcc_pkg;
  // Bus geometry
  localparam int ADCC_ADR_W = 8;
  localparam int ADCC_DAT_W = 32;
  localparam int ADCC_SEL_W = ADCC_DAT_W / 8;

  // Register byte offsets
  localparam logic [ADCC_ADR_W-1:0] ADCC_OFS_CTRL0 = 8'h00;
  localparam logic [ADCC_ADR_W-1:0] ADCC_OFS_CTRL1 = 8'h04;
  localparam logic [ADCC_ADR_W-1:0] ADCC_OFS_CTRL2 = 8'h08;
  localparam logic [ADCC_ADR_W-1:0] ADCC_OFS_RESH = 8'h0c;
  localparam logic [ADCC_ADR_W-1:0] ADCC_OFS_RESL = 8'h10;
  localparam logic [ADCC_ADR_W-1:0] ADCC_OFS_IRQ = 8'h14;
  localparam logic [ADCC_ADR_W-1:0] ADCC_OFS_PINFN = 8'h18;

  // Control 0 fields
  localparam int ADCC_C0_START = 7;
  localparam int ADCC_C0_BUSY = 6;
  localparam int ADCC_C0_PWR = 5;
  localparam int ADCC_C0_FMT = 4;
  localparam int ADCC_C0_CH_LSB = 0;
  localparam int ADCC_CH_W = 3;

  // Control 1 fields
  localparam int ADCC_C1_INSEL_LSB = 5;
  localparam int ADCC_INSEL_W = 3;
  localparam int ADCC_C1_DIV_LSB = 0;
  localparam int ADCC_DIV_W = 3;

  // Control 2 fields
  localparam int ADCC_C2_GAINEN = 7;
  localparam int ADCC_C2_BGEN = 6;
  localparam int ADCC_C2_REF_LSB = 0;
  localparam int ADCC_REF_W = 4;

  // Interrupt control fields
  localparam int ADCC_IRQ_GIE = 0;
  localparam int ADCC_IRQ_IE = 1;
  localparam int ADCC_IRQ_FLAG = 2;

  // Reset values
  localparam logic [7:0] ADCC_BYTE_RST = 8'h00;

  // Conversion timing in converter clock ticks
  localparam logic [3:0] ADCC_SAMPLE_TICKS = 4'h4;
  localparam logic [3:0] ADCC_CONVERT_TICKS = 4'hc;
  localparam int ADCC_RES_W = 12;
  localparam logic [ADCC_RES_W-1:0] ADCC_FULL_SCALE = 12'hfff;
  localparam logic [ADCC_RES_W-1:0] ADCC_SAR_FIRST = 12'h800;

  // Input select codes that mean the external channel
  localparam logic [ADCC_INSEL_W-1:0] ADCC_INSEL_EXT_A = 3'h0;
  localparam logic [ADCC_INSEL_W-1:0] ADCC_INSEL_EXT_B = 3'h4;

  // Reference select codes
  localparam logic [ADCC_REF_W-1:0] ADCC_REF_EXT_X1 = 4'h1;
  localparam logic [ADCC_REF_W-1:0] ADCC_REF_EXT_X4 = 4'h4;
  localparam logic [ADCC_REF_W-1:0] ADCC_REF_BG_X1 = 4'h8;
  localparam logic [ADCC_REF_W-1:0] ADCC_REF_BG_X2 = 4'ha;
  localparam logic [ADCC_REF_W-1:0] ADCC_REF_BG_X4 = 4'hc;

  typedef enum logic [1:0] {
    ADCC_SRC_SUPPLY = 2'h0,
    ADCC_SRC_EXTPIN = 2'h1,
    ADCC_SRC_BANDGAP = 2'h2
  } adcc_ref_src_t;

  typedef enum logic [1:0] {
    ADCC_IDLE = 2'h0,
    ADCC_ARMED = 2'h1,
    ADCC_SAMPLE = 2'h3,
    ADCC_CONVERT = 2'h2
  } adcc_state_t;
endpackage

//--- hdl/adcc_clkdiv.sv
`timescale 1ns/1ns
`default_nettype none
module adcc_clkdiv #(
  parameter int SEL_W = 3,
  parameter int CNT_W = 7
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic [SEL_W-1:0] div_sel_i,
  // Enable pulse out
  output logic tick_o
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] last;
  logic tick_nxt;
  logic tick_r;

  // Terminal count is 2^sel - 1, so code 0 ticks every cycle
  always_comb begin
    last = CNT_W'((1 << div_sel_i) - 1);
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    if (!run_i) begin
      cnt_nxt = '0;
    end else if (cnt_r >= last) begin
      cnt_nxt = '0;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + CNT_W'(1);
    end
  end

  // Divider state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;
endmodule
`default_nettype wire

//--- testbench/adcc_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module adcc_top_asserts #(
  parameter int PINS = 8
) (
  // Clock, reset, bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Front end
  input wire logic analog_power_o,
  input wire logic sample_o,
  input wire logic [11:0] sar_dac_o,
  input wire logic [PINS-1:0] ext_channel_o,
  input wire logic internal_en_o,
  input wire logic [1:0] ref_source_o,
  input wire logic [1:0] ref_gain_o,
  input wire logic irq_o,
  // Pins
  input wire logic [PINS-1:0] port_dir_out_i,
  input wire logic [PINS-1:0] pullup_cfg_i,
  input wire logic [PINS-1:0] pin_analog_o,
  input wire logic [PINS-1:0] pin_digital_en_o,
  input wire logic [PINS-1:0] pin_out_en_n_o,
  input wire logic [PINS-1:0] pullup_en_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Bus answers one cycle later, pulse one cycle wide
  property p_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus ack timing wrong");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == '0;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  // Unpowered: no channel routed, no sampling after a cycle
  property p_pwr_sel;
    !analog_power_o |-> ext_channel_o == '0 && !internal_en_o;
  endproperty
  a_pwr_sel: assert property (p_pwr_sel) else $error("input routed while unpowered");
  property p_pwr_idle;
    !analog_power_o ##1 !analog_power_o |-> !sample_o && sar_dac_o == '0;
  endproperty
  a_pwr_idle: assert property (p_pwr_idle) else $error("converter active while unpowered");
  property p_sample_dac;
    sample_o |-> sar_dac_o == '0;
  endproperty
  a_sample_dac: assert property (p_sample_dac) else $error("trial code during sampling");
  property p_internal;
    internal_en_o |-> ext_channel_o == '0;
  endproperty
  a_internal: assert property (p_internal) else $error("external channel with internal input");
  property p_onehot;
    $onehot0(ext_channel_o);
  endproperty
  a_onehot: assert property (p_onehot) else $error("several channels routed");
  property p_ref_code;
    ref_source_o != 2'h3;
  endproperty
  a_ref_code: assert property (p_ref_code) else $error("bad reference source");
  property p_ref_supply;
    ref_source_o == 2'h0 |-> ref_gain_o == 2'h0;
  endproperty
  a_ref_supply: assert property (p_ref_supply) else $error("gain on supply reference");
  property p_pin_fn;
    pin_digital_en_o == ~pin_analog_o;
  endproperty
  a_pin_fn: assert property (p_pin_fn) else $error("digital function on analogue pin");
  property p_pullup;
    pullup_en_o == (pullup_cfg_i & ~pin_analog_o);
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on analogue pin");
  property p_dir;
    pin_out_en_n_o == ~(port_dir_out_i & ~pin_analog_o);
  endproperty
  a_dir: assert property (p_dir) else $error("driver on analogue pin");

  // Main scenarios reached
  c_sample: cover property ($rose(sample_o));
  c_irq: cover property ($rose(irq_o));
  c_internal: cover property ($rose(internal_en_o));
endmodule

bind adcc_top adcc_top_asserts #(.PINS(PINS)) u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o,
  .analog_power_o, .sample_o, .sar_dac_o, .ext_channel_o, .internal_en_o, .ref_source_o, .ref_gain_o, .irq_o,
  .port_dir_out_i, .pullup_cfg_i, .pin_analog_o, .pin_digital_en_o, .pin_out_en_n_o, .pullup_en_o);
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import adcc_pkg::*;
  // Stimulus and observed signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic comp_i = 1'b0;
  logic analog_power_o, sample_o, internal_en_o, gain_amp_en_o, bandgap_en_o, irq_o;
  logic [11:0] sar_dac_o;
  logic [7:0] ext_channel_o, pin_analog_o, pin_digital_en_o, pin_out_en_n_o, pullup_en_o;
  logic [7:0] port_dir_out_i = 8'h00;
  logic [7:0] pullup_cfg_i = 8'h00;
  logic [2:0] internal_sel_o;
  logic [1:0] ref_source_o, ref_gain_o;
  logic [31:0] rv;
  logic [11:0] vin = 12'h000;
  int mismatches = 0;
  int checked = 0;
  int scnt = 0;

  adcc_top u_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .comp_i, .analog_power_o, .sample_o, .sar_dac_o, .ext_channel_o, .internal_en_o, .internal_sel_o,
    .ref_source_o, .ref_gain_o, .gain_amp_en_o, .bandgap_en_o, .port_dir_out_i, .pullup_cfg_i, .pin_analog_o,
    .pin_digital_en_o, .pin_out_en_n_o, .pullup_en_o, .irq_o);

  always #5 clk_i = ~clk_i;
  // Ideal comparator against the trial code
  always @(posedge clk_i) comp_i <= (vin >= sar_dac_o);
  // Sampling phase length
  always @(posedge clk_i) if (sample_o === 1'b1) scnt <= scnt + 1;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Classic Wishbone cycle; read data lands in rv
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rv = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20) begin
      mismatches++;
      summarize();
    end
  endtask

  task automatic t_regs();
    for (int i = 0; i < 8; i++) begin
      wb(1'b0, 8'(i * 4), 8'h00);
      chk("reset value", 32'h0, rv);
    end
    wb(1'b1, ADCC_OFS_CTRL0, 8'h40);
    wb(1'b0, ADCC_OFS_CTRL0, 8'h00);
    chk("busy read-only", 32'h0, rv);
    wb_sel_i <= 4'he;
    wb(1'b1, ADCC_OFS_CTRL1, 8'h07);
    wb_sel_i <= 4'hf;
    wb(1'b0, ADCC_OFS_CTRL1, 8'h00);
    chk("write without lane 0", 32'h0, rv);
    $display("test registers done");
  endtask

  task automatic t_start();
    wb(1'b1, ADCC_OFS_CTRL1, 8'h03);
    wb(1'b1, ADCC_OFS_CTRL0, 8'h80);
    wb(1'b1, ADCC_OFS_CTRL0, 8'h00);
    wb(1'b0, ADCC_OFS_CTRL0, 8'h00);
    chk("busy unpowered", 32'h0, 32'(rv[6]));
    chk("power unpowered", 32'h0, 32'(analog_power_o));
    wb(1'b1, ADCC_OFS_CTRL0, 8'h20);
    chk("power enabled", 32'h1, 32'(analog_power_o));
    repeat (20) @(posedge clk_i);
    wb(1'b1, ADCC_OFS_CTRL0, 8'ha0);
    repeat (40) @(posedge clk_i);
    wb(1'b0, ADCC_OFS_CTRL0, 8'h00);
    chk("busy with start held", 32'h0, 32'(rv[6]));
    chk("sample with start held", 32'h0, 32'(sample_o));
    wb(1'b1, ADCC_OFS_CTRL0, 8'h20);
    wb(1'b0, ADCC_OFS_CTRL0, 8'h00);
    chk("busy after pulse", 32'h1, 32'(rv[6]));
    wb(1'b1, ADCC_OFS_CTRL0, 8'h00);
    wb(1'b0, ADCC_OFS_CTRL0, 8'h00);
    chk("busy after power off", 32'h0, 32'(rv[6]));
    chk("power after power off", 32'h0, 32'(analog_power_o));
    $display("test start pulse done");
  endtask

  // One conversion at divider d, format f, input v
  task automatic conv(input int d, input logic f, input logic [11:0] v);
    int n;
    time t0;
    n = 0;
    vin = v;
    wb(1'b1, ADCC_OFS_CTRL1, 8'(d));
    wb(1'b1, ADCC_OFS_CTRL0, {3'b001, f, 4'h0});
    repeat (20) @(posedge clk_i);
    wb(1'b1, ADCC_OFS_CTRL0, {3'b101, f, 4'h0});
    scnt = 0;
    wb(1'b1, ADCC_OFS_CTRL0, {3'b001, f, 4'h0});
    t0 = $time;
    wb(1'b0, ADCC_OFS_CTRL0, 8'h00);
    chk("busy at start", 32'h1, 32'(rv[6]));
    while (rv[6] === 1'b1 && n < 3000) begin
      wb(1'b0, ADCC_OFS_CTRL0, 8'h00);
      n++;
    end
    if (n >= 3000) begin
      mismatches++;
      summarize();
    end
    n = int'(($time - t0) / 10);
    chk("conversion time", 32'h1, 32'(n >= (15 << d) - 2 && n <= (17 << d) + 6));
    if (d == 3) begin
      chk("sampling length", 32'h1, 32'(scnt >= 25 && scnt <= 33));
    end
    // Small dividers outrun the comparator synchroniser, so results are skipped there
    if (d >= 3) begin
      wb(1'b0, ADCC_OFS_RESH, 8'h00);
      chk("result high", f ? {28'h0, v[11:8]} : {24'h0, v[11:4]}, rv);
      wb(1'b0, ADCC_OFS_RESL, 8'h00);
      chk("result low", f ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0}, rv);
    end
  endtask

  task automatic t_irq();
    wb(1'b0, ADCC_OFS_IRQ, 8'h00);
    chk("request flag", 32'h4, rv);
    chk("irq disabled", 32'h0, 32'(irq_o));
    wb(1'b1, ADCC_OFS_IRQ, 8'h05);
    chk("irq global only", 32'h0, 32'(irq_o));
    wb(1'b1, ADCC_OFS_IRQ, 8'h07);
    chk("irq both enabled", 32'h1, 32'(irq_o));
    wb(1'b1, ADCC_OFS_IRQ, 8'h03);
    chk("irq after clear", 32'h0, 32'(irq_o));
    $display("test interrupt done");
  endtask

  task automatic t_sel();
    wb(1'b1, ADCC_OFS_CTRL0, 8'h25);
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, ADCC_OFS_CTRL1, {3'(c), 5'h00});
      chk("channel", (c == 0 || c == 4) ? 32'h20 : 32'h0, 32'(ext_channel_o));
      chk("internal", (c == 0 || c == 4) ? 32'h0 : 32'h1, 32'(internal_en_o));
      chk("internal select", 32'(c), 32'(internal_sel_o));
    end
    $display("test input select done");
  endtask

  task automatic t_ref();
    logic [1:0] s;
    logic [1:0] g;
    for (int r = 0; r < 16; r++) begin
      s = (r >= 1 && r <= 4) ? 2'h1 : (r == 8 || (r >= 10 && r <= 12)) ? 2'h2 : 2'h0;
      g = (s == 2'h1) ? 2'(r - 1) : (r >= 10 && r <= 12) ? 2'(r - 9) : 2'h0;
      wb(1'b1, ADCC_OFS_CTRL2, {4'hc, 4'(r)});
      chk("reference", {26'h0, 2'b11, s, g}, {26'h0, gain_amp_en_o, bandgap_en_o, ref_source_o, ref_gain_o});
    end
    $display("test reference done");
  endtask

  task automatic t_pins();
    port_dir_out_i <= 8'hff;
    pullup_cfg_i <= 8'h5a;
    wb(1'b1, ADCC_OFS_PINFN, 8'h0f);
    chk("analogue pins", 32'h0f, 32'(pin_analog_o));
    chk("digital enable", 32'hf0, 32'(pin_digital_en_o));
    chk("pull-up", 32'h50, 32'(pullup_en_o));
    chk("output enable", 32'h0f, 32'(pin_out_en_n_o));
    $display("test pins done");
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_start();
    conv(0, 1'b0, 12'h5a3);
    conv(1, 1'b1, 12'h5a3);
    conv(2, 1'b0, 12'h5a3);
    conv(3, 1'b1, 12'hfff);
    conv(4, 1'b0, 12'h000);
    conv(5, 1'b1, 12'ha5c);
    conv(6, 1'b0, 12'hc3e);
    conv(7, 1'b0, 12'h7f1);
    $display("test conversions done");
    t_irq();
    t_sel();
    t_ref();
    t_pins();
    summarize();
  end
endmodule
`default_nettype wire
